// ==== host_port_device.sv ====
// device end: pairs 16-bit host accesses into dwords with endian/swap
// assumes one clock; inner side offers dword read data on request
`timescale 1ns/1ps
`include "host_port_consts.svh"

module host_port_device
   import host_port_pkg::*;
#(
   parameter int unsigned DEPTH = `BUF_DEPTH
)
(
   // clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  srst,
   // link
   host_port_if.dev                   bus,
   // configuration levels
   input  wire logic                  fifo_port_big_endian,
   input  wire logic                  direct_select_big_endian,
   input  wire logic [`DWORD_W-1:0]   word_swap,
   // committed write dwords
   output logic                       wr_valid_q,
   output logic [`DW_ADDR_W-1:0]      wr_addr_q,
   output logic                       wr_sel_q,
   output logic [`DWORD_W-1:0]        wr_data_q,
   input  wire logic                  wr_ready,
   // read dword fetch
   output logic                       rd_req_q,
   output logic [`DW_ADDR_W-1:0]      rd_addr_q,
   output logic                       rd_sel_q,
   input  wire logic                  rd_ack,
   input  wire logic [`DWORD_W-1:0]   rd_dword
);

   localparam int unsigned ENT_W = `DW_ADDR_W + 1 + `DWORD_W;

   logic                    acc_ready_q;
   logic                    rd_valid_q;
   logic [`HALF_W-1:0]      rd_data_q;
   logic                    wpend_q;
   logic                    whalf_q;
   logic [`DW_ADDR_W-1:0]   waddr_q;
   logic [`HALF_W-1:0]      whold_q;
   logic                    rpend_q;
   logic                    rhalf_q;
   logic [`DW_ADDR_W-1:0]   raddr_q;
   logic                    rsel_q;
   logic [`DWORD_W-1:0]     rbus_q;
   logic                    rbusy_q;
   logic [ENT_W-1:0]        ent_q [DEPTH];
   logic [1:0]              cnt_q;
   logic [1:0]              cnt_d;
   logic                    push;
   logic                    pop;
   logic                    wr_acc;
   logic                    rd_acc;
   logic                    a1;
   logic [`DW_ADDR_W-1:0]   dwa;
   logic                    fetch;
   logic [`DWORD_W-1:0]     bus_dw;
   logic [ENT_W-1:0]        new_ent;
   logic [`DWORD_W-1:0]     rmap;

   assign bus.acc_ready = acc_ready_q;
   assign bus.rd_valid  = rd_valid_q;
   assign bus.rd_data   = rd_data_q;

   assign wr_acc = bus.acc_valid && bus.acc_write;
   assign rd_acc = bus.acc_valid && !bus.acc_write;
   assign a1     = bus.acc_addr[1];
   assign dwa    = bus.acc_addr[`ADDR_HI:2];

   // ----------------------------------------------------------------
   // path classification
   // ----------------------------------------------------------------
   // endian choice per path; registers and status fifo stay little
   function automatic logic path_big(input logic sel, input logic [`DW_ADDR_W-1:0] a);
      path_t p;
      p = sel ? PATH_DIRECT_SEL : (a <= `FIFO_PORT_LAST) ? PATH_FIFO_PORT : PATH_OTHER;
      unique case (p)
         PATH_FIFO_PORT:  path_big = fifo_port_big_endian;
         PATH_DIRECT_SEL: path_big = direct_select_big_endian;
         default:         path_big = 1'b0;
      endcase
   endfunction : path_big

   // swap only for the all-ones setting, on every path
   function automatic logic swap_on();
      swap_on = (word_swap == `WORD_SWAP_ON);
   endfunction : swap_on

   // ----------------------------------------------------------------
   // write half pairing
   // ----------------------------------------------------------------
   // bus-order dword from held half and the new one
   assign bus_dw = a1 ? {bus.acc_wdata, whold_q} : {whold_q, bus.acc_wdata};
   // same mapping undoes the bus order: swap, then endian
   // a process, not an assign, so the config levels read by the functions wake it
   always_comb
   begin
      new_ent = {dwa, bus.acc_sel, lane_map(bus_dw, path_big(bus.acc_sel, dwa), swap_on())};
   end
   // opposite half of the same dword completes it
   assign push = wr_acc && wpend_q && (a1 != whalf_q) && (dwa == waddr_q);

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         wpend_q <= 1'b0;
         whalf_q <= 1'b0;
         waddr_q <= '0;
         whold_q <= '0;
      end
      else if (wr_acc)
      begin
         if (!wpend_q || dwa != waddr_q)
         begin
            // first half, or a moved address opens a fresh dword
            wpend_q <= 1'b1;
            whalf_q <= a1;
            waddr_q <= dwa;
            whold_q <= bus.acc_wdata;
         end
         else
            wpend_q <= 1'b0;   // pair done, or same half: transfer dropped
      end
   end

   // ----------------------------------------------------------------
   // two-entry buffer, head always in entry 0
   // ----------------------------------------------------------------
   // shifting keeps the outputs straight from flops at the cost of a move
   assign pop = wr_valid_q && wr_ready;

   always_comb
   begin
      cnt_d = cnt_q;
      if (push && !pop)
         cnt_d = cnt_q + 2'd1;
      else if (pop && !push)
         cnt_d = cnt_q - 2'd1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         cnt_q <= '0;
         for (int i = 0; i < DEPTH; i++)
            ent_q[i] <= '0;
      end
      else
      begin
         cnt_q <= cnt_d;
         if (pop)
         begin
            ent_q[0] <= (push && cnt_q == 2'd1) ? new_ent : ent_q[1];
            if (push && cnt_q == 2'd2)
               ent_q[1] <= new_ent;
         end
         else if (push)
            ent_q[cnt_q[0]] <= new_ent;   // commit the assembled dword
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         wr_valid_q <= 1'b0;
         wr_addr_q  <= '0;
         wr_sel_q   <= 1'b0;
         wr_data_q  <= '0;
      end
      else
      begin
         wr_valid_q <= (cnt_d != 2'd0);
         if (pop)
            {wr_addr_q, wr_sel_q, wr_data_q} <= (cnt_q == 2'd1) ? new_ent : ent_q[1];
         else if (cnt_q == 2'd0 && push)
            {wr_addr_q, wr_sel_q, wr_data_q} <= new_ent;
      end
   end

   // ----------------------------------------------------------------
   // read half pairing and fetch
   // ----------------------------------------------------------------
   // fetch unless this dword is pending; a repeated half is answered stale, no fetch
   assign fetch = rd_acc && !(rpend_q && dwa == raddr_q);

   // fetched dword in bus lane order: endian first, then swap
   always_comb
   begin
      rmap = lane_map(rd_dword, path_big(rsel_q, raddr_q), swap_on());
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         rpend_q   <= 1'b0;
         rhalf_q   <= 1'b0;
         raddr_q   <= '0;
         rsel_q    <= 1'b0;
         rbus_q    <= '0;
         rbusy_q   <= 1'b0;
         rd_req_q  <= 1'b0;
         rd_addr_q <= '0;
         rd_sel_q  <= 1'b0;
         rd_valid_q <= 1'b0;
         rd_data_q <= '0;
      end
      else
      begin
         rd_req_q   <= 1'b0;
         rd_valid_q <= 1'b0;
         if (rd_acc && rpend_q && a1 == rhalf_q && dwa == raddr_q)
         begin
            // repeated half: answer stale data, tracking restarts
            rpend_q    <= 1'b0;
            rd_valid_q <= 1'b1;
            rd_data_q  <= a1 ? rbus_q[31:16] : rbus_q[15:0];
         end
         else if (fetch)
         begin
            rhalf_q   <= a1;
            raddr_q   <= dwa;
            rsel_q    <= bus.acc_sel;
            rbusy_q   <= 1'b1;
            rd_req_q  <= 1'b1;
            rd_addr_q <= dwa;
            rd_sel_q  <= bus.acc_sel;
         end
         else if (rd_acc)
         begin
            rpend_q    <= 1'b0;   // second half closes the dword
            rd_valid_q <= 1'b1;
            rd_data_q  <= a1 ? rbus_q[31:16] : rbus_q[15:0];
         end
         if (rbusy_q && rd_ack)
         begin
            // endian first, then swap, into bus lane order
            rbus_q     <= rmap;
            rbusy_q    <= 1'b0;
            rpend_q    <= 1'b1;
            rd_valid_q <= 1'b1;
            rd_data_q  <= rhalf_q ? rmap[31:16] : rmap[15:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // back-pressure: room for a whole dword and no fetch in flight
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         acc_ready_q <= 1'b0;
      else
         acc_ready_q <= (cnt_d != 2'd2) && !(fetch || (rbusy_q && !rd_ack));
   end

endmodule : host_port_device

// ==== host_port_consts.svh ====
// constants for the 16-bit host port and its dword assembly
// assumes inclusion by bare name from the package and both ends
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH

// ----------------------------------------------------------------
// host bus geometry
// ----------------------------------------------------------------
`define HALF_W           16
`define DWORD_W          32
`define ADDR_HI          7
`define DW_ADDR_W        6
// last dword index of the data fifo port window (byte 00h..3Ch)
`define FIFO_PORT_LAST   6'h0f

// ----------------------------------------------------------------
// word swap setting and buffering
// ----------------------------------------------------------------
`define WORD_SWAP_ON     32'hffff_ffff
`define BUF_DEPTH        2

`endif

// ==== host_port_pkg.sv ====
// types and lane mapping shared by both ends of the host port
// assumes the constants header is on the include path
`include "host_port_consts.svh"

package host_port_pkg;

   // ----------------------------------------------------------------
   // access path classes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PATH_FIFO_PORT,
      PATH_DIRECT_SEL,
      PATH_OTHER
   } path_t;

   typedef enum logic [2:0] {
      H_IDLE,
      H_FIRST,
      H_SECOND,
      H_WAIT1,
      H_WAIT2
   } host_state_t;

   // bus-order dword {half at bit1 set, half at bit1 clear} from internal
   // order; both steps are involutions and commute, so the same function
   // serves reads and writes in their required order
   function automatic logic [`DWORD_W-1:0] lane_map(
      input logic [`DWORD_W-1:0] d,
      input logic                big,
      input logic                swap
   );
      logic [`DWORD_W-1:0] e;
      e = big ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
      lane_map = swap ? {e[15:0], e[31:16]} : e;
   endfunction : lane_map

endpackage : host_port_pkg

// ==== host_port_if.sv ====
// link between the host end and the device end of the 16-bit port
// assumes one shared clock; one access per acc_valid pulse
`timescale 1ns/1ps
`include "host_port_consts.svh"

interface host_port_if;
   logic                acc_valid;  // one-cycle access strobe
   logic                acc_write;  // 1 write, 0 read
   logic                acc_sel;    // direct fifo select input
   logic [`ADDR_HI:1]   acc_addr;   // bit 1 picks the half
   logic [`HALF_W-1:0]  acc_wdata;
   logic                acc_ready;  // device can take an access
   logic                rd_valid;   // one-cycle read answer
   logic [`HALF_W-1:0]  rd_data;

   modport dev (input acc_valid, acc_write, acc_sel, acc_addr, acc_wdata,
                output acc_ready, rd_valid, rd_data);
   modport hst (output acc_valid, acc_write, acc_sel, acc_addr, acc_wdata,
                input acc_ready, rd_valid, rd_data);
endinterface : host_port_if

// ==== host_port_host.sv ====
// host end: splits user dword commands into two 16-bit accesses
// assumes the device end on the other side of host_port_if
`timescale 1ns/1ps
`include "host_port_consts.svh"

module host_port_host
   import host_port_pkg::*;
(
   // clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  srst,
   // link
   host_port_if.hst                   bus,
   // user command
   input  wire logic                  cmd_valid,
   input  wire logic                  cmd_write,
   input  wire logic                  cmd_sel,
   input  wire logic                  cmd_low_first,
   input  wire logic [`DW_ADDR_W-1:0] cmd_addr,
   input  wire logic [`DWORD_W-1:0]   cmd_wdata,
   output logic                       cmd_ready_q,
   // user answer
   output logic                       rsp_valid_q,
   output logic [`DWORD_W-1:0]        rsp_data_q
);

   host_state_t             st_q;
   logic                    wr_q;
   logic                    sel_q;
   logic                    low_q;
   logic [`DW_ADDR_W-1:0]   adr_q;
   logic [`DWORD_W-1:0]     dat_q;
   logic                    acc_valid_q;
   logic                    acc_write_q;
   logic                    acc_sel_q;
   logic [`ADDR_HI:1]       acc_addr_q;
   logic [`HALF_W-1:0]      acc_wdata_q;
   logic                    half;
   logic                    go;

   assign bus.acc_valid = acc_valid_q;
   assign bus.acc_write = acc_write_q;
   assign bus.acc_sel   = acc_sel_q;
   assign bus.acc_addr  = acc_addr_q;
   assign bus.acc_wdata = acc_wdata_q;

   // half for the current step: first half is low when low_q, then the other
   assign half = (st_q == H_FIRST) ? ~low_q : low_q;
   // writes and reads alike wait for acc_ready and no strobe in the last cycle
   assign go = bus.acc_ready && !acc_valid_q;

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         st_q        <= H_IDLE;
         cmd_ready_q <= 1'b0;
         acc_valid_q <= 1'b0;
         rsp_valid_q <= 1'b0;
      end
      else
      begin
         acc_valid_q <= 1'b0;
         rsp_valid_q <= 1'b0;
         cmd_ready_q <= 1'b0;
         unique case (st_q)
            H_IDLE:
            begin
               cmd_ready_q <= 1'b1;
               if (cmd_valid && cmd_ready_q)
               begin
                  cmd_ready_q <= 1'b0;
                  st_q        <= H_FIRST;
               end
            end
            H_FIRST, H_SECOND:
               if (go)
               begin
                  acc_valid_q <= 1'b1;   // same dword address both halves
                  if (wr_q)
                     st_q <= (st_q == H_FIRST) ? H_SECOND : H_IDLE;   // second half next, no wait for an answer
                  else
                     st_q <= (st_q == H_FIRST) ? H_WAIT1 : H_WAIT2;
               end
            H_WAIT1:
               if (bus.rd_valid)
                  st_q <= H_SECOND;
            H_WAIT2:
               if (bus.rd_valid)
               begin
                  rsp_valid_q <= 1'b1;
                  st_q        <= H_IDLE;
               end
            default:
               st_q <= H_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // command capture, pin drive and read assembly
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         wr_q        <= 1'b0;
         sel_q       <= 1'b0;
         low_q       <= 1'b0;
         adr_q       <= '0;
         dat_q       <= '0;
         acc_write_q <= 1'b0;
         acc_sel_q   <= 1'b0;
         acc_addr_q  <= '0;
         acc_wdata_q <= '0;
         rsp_data_q  <= '0;
      end
      else
      begin
         if (st_q == H_IDLE && cmd_valid && cmd_ready_q)
         begin
            wr_q  <= cmd_write;
            sel_q <= cmd_sel;
            low_q <= cmd_low_first;
            adr_q <= cmd_addr;
            dat_q <= cmd_wdata;
         end
         if ((st_q == H_FIRST || st_q == H_SECOND) && go)
         begin
            acc_write_q <= wr_q;
            acc_sel_q   <= sel_q;
            acc_addr_q  <= {adr_q, half};
            acc_wdata_q <= half ? dat_q[31:16] : dat_q[15:0];
         end
         // answer word keeps bus lane order: upper half came at bit 1 set
         if (bus.rd_valid)
         begin
            if (acc_addr_q[1])
               rsp_data_q[31:16] <= bus.rd_data;
            else
               rsp_data_q[15:0] <= bus.rd_data;
         end
      end
   end

endmodule : host_port_host

// ==== host_port_checker.sv ====
// concurrent checks on the link between host end and device end
// assumes plain link signals, one clock, sync active-high reset
`timescale 1ns/1ps
`include "host_port_consts.svh"

module host_port_checker
   import host_port_pkg::*;
(
   // clock and reset
   input wire logic              sys_clk,
   input wire logic              srst,
   // link
   input wire logic              acc_valid,
   input wire logic              acc_write,
   input wire logic [`ADDR_HI:1] acc_addr,
   input wire logic              acc_ready,
   input wire logic              rd_valid
);
   // ----------------------------------------------------------------
   // pair tracking
   // ----------------------------------------------------------------
   logic              pend_q;
   logic              pwr_q;
   logic [`ADDR_HI:1] padr_q;

   // first access opens a dword, the next one closes it
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         pend_q <= 1'h0;
      else if (acc_valid)
         pend_q <= !pend_q;
   end

   // direction and address of the opening half, kept for the closing one
   always_ff @(posedge sys_clk)
   begin
      if (acc_valid)
      begin
         pwr_q  <= acc_write;
         padr_q <= acc_addr;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   a_take_when_ready: assert property (acc_valid |-> acc_ready)
      else $error("access strobe while device not ready");
   a_no_back_to_back: assert property (acc_valid |=> !acc_valid)
      else $error("access strobe held two cycles");
   a_write_pair_dword: assert property (acc_valid && pend_q && pwr_q |-> acc_write
      && acc_addr[`ADDR_HI:2] == padr_q[`ADDR_HI:2] && acc_addr[1] != padr_q[1])
      else $error("write halves not paired within one dword");
   a_read_pair_dword: assert property (acc_valid && pend_q && !pwr_q |-> !acc_write
      && acc_addr[`ADDR_HI:2] == padr_q[`ADDR_HI:2] && acc_addr[1] != padr_q[1])
      else $error("read halves not paired within one dword");
   a_read_answered: assert property (acc_valid && !acc_write |-> ##[1:40] rd_valid)
      else $error("read access left without answer");
   a_fetch_blocks_ready: assert property (acc_valid && !acc_write && !pend_q |=> !acc_ready)
      else $error("device ready while fetching a dword");
   a_half_answer_next: assert property (acc_valid && !acc_write && pend_q |=> rd_valid)
      else $error("second read half not answered next cycle");
   a_answer_pulse: assert property (rd_valid |=> !rd_valid)
      else $error("read answer longer than one cycle");

   // main traffic kinds
   c_write_pair: cover property (acc_valid && pend_q && pwr_q);
   c_read_fetch: cover property (acc_valid && !acc_write && !pend_q);
   c_read_second: cover property (acc_valid && !acc_write && pend_q);
endmodule : host_port_checker

// ==== tb_host_bus_dword_endian_port.sv ====
// bench: host end and device end back to back, plus a second device
// end driven raw to provoke badly paired accesses
// assumes 100 ns clock and sync active-high reset
`timescale 1ns/1ps
`include "host_port_consts.svh"

module tb_host_bus_dword_endian_port
   import host_port_pkg::*;
;
   // ----------------------------------------------------------------
   // signals and instances
   // ----------------------------------------------------------------
   logic        sys_clk = 1'h0, srst = 1'h1, stall = 1'h0;
   logic        cmd_valid = 1'h0, cmd_write = 1'h0, cmd_sel = 1'h0, cmd_low_first = 1'h0;
   logic [5:0]  cmd_addr = 6'h0;
   logic [31:0] cmd_wdata = 32'h0, word_swap = 32'h0, rd_val = 32'h0, rnd = 32'hec659328;
   logic        fport_be = 1'h0, dsel_be = 1'h0, wr_ready = 1'h0, rd_ack = 1'h0;
   logic        cmd_ready_q, rsp_valid_q, wr_valid_q, wr_sel_q, fw_valid, rd_req, rd_sel;
   logic [31:0] rsp_data_q, wr_data_q, fw_data;
   logic [5:0]  wr_addr_q, rd_addr;
   logic [16:0] e;
   logic [38:0] exp_w[$];
   logic [31:0] exp_r[$], exp_f[$];
   logic [16:0] exp_b[$];
   logic [6:0]  exp_a[$];
   int          n_fail = 0, check_count = 0, nb_rd = 0;

   host_port_if bus_a ();
   host_port_if bus_b ();

   host_port_host i_host_port_host (.sys_clk, .srst, .bus(bus_a), .cmd_valid, .cmd_write, .cmd_sel,
      .cmd_low_first, .cmd_addr, .cmd_wdata, .cmd_ready_q, .rsp_valid_q, .rsp_data_q);
   host_port_device i_host_port_device (.sys_clk, .srst, .bus(bus_a), .fifo_port_big_endian(fport_be),
      .direct_select_big_endian(dsel_be), .word_swap, .wr_valid_q, .wr_addr_q, .wr_sel_q, .wr_data_q,
      .wr_ready, .rd_req_q(rd_req), .rd_addr_q(rd_addr), .rd_sel_q(rd_sel), .rd_ack, .rd_dword(rd_val));
   host_port_device i_host_port_device_f (.sys_clk, .srst, .bus(bus_b), .fifo_port_big_endian(fport_be),
      .direct_select_big_endian(dsel_be), .word_swap, .wr_valid_q(fw_valid), .wr_addr_q(), .wr_sel_q(),
      .wr_data_q(fw_data), .wr_ready, .rd_req_q(), .rd_addr_q(), .rd_sel_q(), .rd_ack, .rd_dword(rd_val));
   host_port_checker i_host_port_checker (.sys_clk, .srst, .acc_valid(bus_a.acc_valid),
      .acc_write(bus_a.acc_write), .acc_addr(bus_a.acc_addr), .acc_ready(bus_a.acc_ready),
      .rd_valid(bus_a.rd_valid));

   always #50 sys_clk = ~sys_clk;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] nxt(input logic [31:0] s);
      nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt

   // bus order from internal order and back: both steps undo themselves
   function automatic logic [31:0] conv(input logic [31:0] b, input logic big, input logic sw);
      logic [31:0] s;
      s = sw ? {b[15:0], b[31:16]} : b;
      conv = big ? {s[7:0], s[15:8], s[23:16], s[31:24]} : s;
   endfunction : conv

   // notes still waiting for their result
   function automatic int pending();
      pending = exp_w.size() + exp_r.size() + exp_f.size() + exp_b.size() + exp_a.size();
   endfunction : pending

   task automatic check(input string nm, input logic [38:0] seen, input logic [38:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict

   // one user dword command; the expectation is noted before it goes out
   task automatic cmd(input logic w, input logic sel, input logic [5:0] a, input logic [31:0] d,
                      input logic lf);
      logic big;
      big = sel ? dsel_be : (a <= `FIFO_PORT_LAST) && fport_be;
      if (w)
         exp_w.push_back({sel, a, conv(d, big, word_swap === `WORD_SWAP_ON)});
      else
      begin
         exp_r.push_back(conv(rd_val, big, word_swap === `WORD_SWAP_ON));
         exp_a.push_back({sel, a});
      end
      @(negedge sys_clk);
      for (int i = 0; i < 300 && cmd_ready_q !== 1'h1; i++) @(negedge sys_clk);
      {cmd_valid, cmd_write, cmd_sel, cmd_addr, cmd_wdata, cmd_low_first} = {1'h1, w, sel, a, d, lf};
      @(negedge sys_clk);
      cmd_valid = 1'h0;
   endtask : cmd

   // raw access on the second link; released data is inverted so it never lingers
   task automatic raw(input logic w, input logic [7:1] a, input logic [15:0] d);
      int n;
      n = nb_rd;
      @(negedge sys_clk);
      for (int i = 0; i < 300 && bus_b.acc_ready !== 1'h1; i++) @(negedge sys_clk);
      {bus_b.acc_valid, bus_b.acc_write, bus_b.acc_addr, bus_b.acc_wdata} = {1'h1, w, a, d};
      @(negedge sys_clk);
      bus_b.acc_valid = 1'h0;
      bus_b.acc_wdata = ~d;
      for (int i = 0; i < 300 && !w && nb_rd == n; i++) @(negedge sys_clk);
   endtask : raw

   task automatic drain();
      for (int i = 0; i < 400 && pending() != 0; i++)
         @(posedge sys_clk);
      check("left over", 39'(pending()), 39'h0);
      @(negedge sys_clk);
   endtask : drain

   // ----------------------------------------------------------------
   // inner side and result watcher
   // ----------------------------------------------------------------
   // random stalls; stall backs up the write side until the device refuses
   always @(negedge sys_clk)
   begin
      rnd      <= nxt(rnd);
      wr_ready <= rnd[0] && !stall;
      rd_ack   <= rnd[3];
   end

   // pre-edge values at each rising edge, so results land in a fixed order
   always @(posedge sys_clk)
   begin
      if (!srst && wr_valid_q && wr_ready)
         check("wr dword", {wr_sel_q, wr_addr_q, wr_data_q}, exp_w.pop_front());
      if (!srst && rsp_valid_q)
         check("rd dword", 39'(rsp_data_q), 39'(exp_r.pop_front()));
      if (!srst && rd_req)
         check("rd fetch", 39'({rd_sel, rd_addr}), 39'(exp_a.pop_front()));
      if (!srst && fw_valid && wr_ready)
         check("bad pair wr", 39'(fw_data), 39'(exp_f.pop_front()));
      if (!srst && bus_b.rd_valid)
      begin
         nb_rd++;
         e = exp_b.pop_front();
         if (e[16])
            check("bad pair rd", 39'(bus_b.rd_data), 39'(e[15:0]));
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      logic [31:0] d;
      logic [5:0]  a;
      {bus_b.acc_valid, bus_b.acc_write, bus_b.acc_sel, bus_b.acc_addr, bus_b.acc_wdata} = '0;
      repeat (20) @(negedge sys_clk);
      srst = 1'h0;
      repeat (3) @(negedge sys_clk);
      // every swap and endian setting against every access path, both directions
      for (int c = 0; c < 12; c++)
         for (int p = 0; p < 3; p++)
            for (int w = 0; w < 2; w++)
            begin
               @(posedge sys_clk);
               d = rnd;
               @(negedge sys_clk);
               {fport_be, dsel_be} = c[1:0];
               word_swap = (c < 4) ? 32'h0 : (c < 8) ? `WORD_SWAP_ON : (d & 32'hfffe_ffff);
               rd_val = ~d;
               a = (p == 2) ? d[5:0] : (p == 1) ? (6'h10 | d[5:0]) : {2'h0, d[3:0]};
               cmd(w[0], p == 2, a, d, d[6]);
               drain();
            end
      // back up the write side, then let it drain in order
      stall = 1'h1;
      for (int k = 0; k < 3; k++)
         cmd(1'h1, 1'h0, 6'(k), 32'h1234_5678 + k, k[0]);
      repeat (20) @(negedge sys_clk);
      check("ready when full", 39'(bus_a.acc_ready), 39'h0);
      stall = 1'h0;
      drain();
      // second link: same half written twice is dropped, a fresh pair follows
      {fport_be, dsel_be, word_swap} = '0;
      exp_f.push_back(32'hc3c3_5a5a);
      raw(1'h1, {6'h12, 1'h1}, 16'h1111);
      raw(1'h1, {6'h12, 1'h1}, 16'h2222);
      raw(1'h1, {6'h12, 1'h0}, 16'h5a5a);
      raw(1'h1, {6'h12, 1'h1}, 16'hc3c3);
      // same half read twice: second answer is not trusted, next read fetches anew
      rd_val = 32'h0f1e_2d3c;
      exp_b.push_back({1'h1, 16'h0f1e});
      raw(1'h0, {6'h12, 1'h1}, 16'h0);
      exp_b.push_back(17'h0);
      raw(1'h0, {6'h12, 1'h1}, 16'h0);
      rd_val = 32'h8877_6655;
      exp_b.push_back({1'h1, 16'h6655});
      raw(1'h0, {6'h12, 1'h0}, 16'h0);
      exp_b.push_back({1'h1, 16'h8877});
      raw(1'h0, {6'h12, 1'h1}, 16'h0);
      drain();
      print_verdict();
   end

   // a hang ends the run here; the sweep needs only about a thousand cycles
   initial
   begin
      repeat (50000) @(posedge sys_clk);
      n_fail++;
      print_verdict();
   end
endmodule : tb_host_bus_dword_endian_port
